// *** tb/wdcs_chk.sv ***
// Port checker for the watchdog control block
`timescale 1ns/100ps
module wdcs_chk (
	input wire CLK_SYS,
	input wire RST_N,
	input wire [4:0] AVS_ADDRESS,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	input wire [3:0] AVS_BYTEENABLE,
	input wire [31:0] AVS_READDATA,
	input wire AVS_WAITREQUEST,
	input wire INT_RST_OUT,
	input wire WDT_RUN,
	input wire WDT_RESET_FLAG
);
default clocking cb @(posedge CLK_SYS); endclocking
default disable iff (!RST_N);
wire ctl_wr = AVS_WRITE && AVS_BYTEENABLE[0] && !AVS_WAITREQUEST && AVS_ADDRESS[4:2] == 3'h0;
sequence s_req;
	$rose(AVS_READ || AVS_WRITE) ##0 AVS_WAITREQUEST;
endsequence
sequence s_ack;
	##1 !AVS_WAITREQUEST;
endsequence
a_wait_one: assert property (s_req |-> s_ack) else $error("bad wait state");
a_gate_read: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[4:2] == 3'h0
	|-> (AVS_READDATA[7:0] & 8'hAA) == 8'hAA) else $error("gate bit read 0");
// Reset itself is checked, so this one is never disabled
a_run_reset: assert property (disable iff (1'b0) !RST_N |=> WDT_RUN && !WDT_RESET_FLAG)
	else $error("bad reset state");
a_ovf_flags: assert property ($rose(INT_RST_OUT) |-> WDT_RESET_FLAG && WDT_RUN)
	else $error("overflow state wrong");
a_pulse_one: assert property (INT_RST_OUT |=> !INT_RST_OUT) else $error("reset pulse too long");
a_flag_cause: assert property ($rose(WDT_RESET_FLAG)
	|-> INT_RST_OUT) else $error("flag set without cause");
a_run_fall: assert property ($fell(WDT_RUN) |-> $past(ctl_wr && AVS_WRITEDATA[3:2] == 2'b00))
	else $error("run cleared without write");
a_run_rise: assert property ($rose(WDT_RUN)
	|-> INT_RST_OUT || $past(ctl_wr && AVS_WRITEDATA[3:2] == 2'b01)) else $error("run set without cause");
a_flag_fall: assert property ($fell(WDT_RESET_FLAG) |-> $past(ctl_wr && AVS_WRITEDATA[1:0] == 2'b00))
	else $error("flag cleared without write");
endmodule // wdcs_chk
bind wdcs_top wdcs_chk u_chk (.CLK_SYS, .RST_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
	.AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .INT_RST_OUT, .WDT_RUN, .WDT_RESET_FLAG);

// *** tb/wdcs_top_bench.sv ***
// Self-checking bench for the watchdog control block
`timescale 1ns/100ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fail_count++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module wdcs_top_bench;
typedef struct packed {logic [4:0] wa; logic [7:0] wd; logic [4:0] ra; logic [7:0] re; logic irq;} wdcs_row_t;
// Write, then read back; rows 11 to 14 need an overflow first
wdcs_row_t rows [15] = '{
	'{5'h00, 8'hDF, 5'h00, 8'hBE, 1'b0}, '{5'h00, 8'hF3, 5'h00, 8'hBA, 1'b0},
	'{5'h00, 8'h7F, 5'h00, 8'hFA, 1'b0}, '{5'h00, 8'hAA, 5'h00, 8'hFA, 1'b0},
	'{5'h04, 8'h55, 5'h04, 8'h55, 1'b0}, '{5'h00, 8'h3F, 5'h00, 8'hBA, 1'b0},
	'{5'h04, 8'h11, 5'h04, 8'h55, 1'b0}, '{5'h0C, 8'h02, 5'h08, 8'h02, 1'b1},
	'{5'h10, 8'h02, 5'h08, 8'h00, 1'b0}, '{5'h00, 8'h57, 5'h00, 8'hFE, 1'b0},
	'{5'h14, 8'hFF, 5'h14, 8'h00, 1'b0}, '{5'h00, 8'h00, 5'h00, 8'hAF, 1'b1},
	'{5'h00, 8'hDF, 5'h00, 8'hBF, 1'b0}, '{5'h00, 8'hD0, 5'h00, 8'hBA, 1'b0},
	'{5'h00, 8'hD1, 5'h00, 8'hBA, 1'b0}};
logic CLK_SYS = 1'b0;
logic RST_N = 1'b0;
logic AVS_READ = 1'b0;
logic AVS_WRITE = 1'b0;
logic [4:0] AVS_ADDRESS = 5'h00;
logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
logic [3:0] AVS_BYTEENABLE = 4'h1;
wire [31:0] AVS_READDATA;
wire AVS_WAITREQUEST, IRQ, INT_RST_OUT, WDT_RUN, WDT_RESET_FLAG;
int fail_count = 0;
int compares = 0;
int cycles = 0;
logic [31:0] q;
logic irq_s;
always #12.5 CLK_SYS = ~CLK_SYS;
wdcs_top dut (.CLK_SYS, .RST_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE,
	.AVS_READDATA, .AVS_WAITREQUEST, .IRQ, .INT_RST_OUT, .WDT_RUN, .WDT_RESET_FLAG);
////////////////////////////////////////////////////////////////////////
task complete_run;
	if (fail_count == 0 && compares > 0)
		$display("bench passed");
	else
		$display("bench failed");
	$finish;
endtask
// Two overflows need about 540 cycles
always @(posedge CLK_SYS) begin
	cycles++;
	if (cycles == 3000) begin
		fail_count++;
		complete_run();
	end
end
// Waitrequest and read data are taken at the rising edge that ends the wait, then the request drops
task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
	AVS_ADDRESS <= a;
	AVS_WRITEDATA <= {24'h00_0000, d};
	AVS_WRITE <= w;
	AVS_READ <= !w;
	do @(posedge CLK_SYS); while (AVS_WAITREQUEST !== 1'b0);
	q = AVS_READDATA;
	irq_s = IRQ;
	AVS_WRITE <= 1'b0;
	AVS_READ <= 1'b0;
	@(posedge CLK_SYS);
endtask
task row(input int i);
	bus(1'b1, rows[i].wa, rows[i].wd);
	bus(1'b0, rows[i].ra, 8'h00);
	`CHK("rdata", {24'h00_0000, rows[i].re}, q)
	`CHK("irq", rows[i].irq, irq_s)
endtask
task do_reset;
	RST_N <= 1'b0;
	repeat (8) @(posedge CLK_SYS);
	RST_N <= 1'b1;
	@(posedge CLK_SYS);
	bus(1'b0, 5'h00, 8'h00);
	`CHK("rst", 32'h0000_00AE, q)
endtask
task wait_ovf;
	do @(negedge CLK_SYS); while (INT_RST_OUT !== 1'b1);
	`CHK("run", 1'b1, WDT_RUN)
	`CHK("flag", 1'b1, WDT_RESET_FLAG)
	@(posedge CLK_SYS);
endtask
////////////////////////////////////////////////////////////////////////
initial begin
	do_reset();
	for (int i = 0; i < 11; i++)
		row(i);
	wait_ovf();
	bus(1'b0, 5'h08, 8'h00);
	`CHK("stat", 32'h0000_0001, q)
	row(11);
	do_reset();
	wait_ovf();
	row(12);
	row(13);
	row(14);
	AVS_BYTEENABLE <= 4'h0;
	bus(1'b1, 5'h00, 8'h7F);
	AVS_BYTEENABLE <= 4'h1;
	bus(1'b0, 5'h00, 8'h00);
	`CHK("be0", 32'h0000_00BA, q)
	complete_run();
end
endmodule // wdcs_top_bench

// *** verilog/wdcs_cnt.v ***
// Watchdog up-counter with tick divider, software load and overflow detection
`timescale 1ns/100ps
module wdcs_cnt #(
	parameter W = 8,
	parameter DIV = 1
) (
	input wire clk,
	input wire rst_n,
	input wire init,
	input wire run,
	input wire load,
	input wire [W-1:0] load_val,
	output reg [W-1:0] count_r,
	output wire ovf
);

	reg [15:0] div_r;
	reg [15:0] div_nxt;
	reg [W-1:0] count_nxt;
	wire tick;

	assign tick = (div_r == (DIV[15:0] - 16'h0001));
	// A load in the same cycle wins, so no overflow is reported then
	assign ovf = tick && run && !load && (&count_r);

	always @* begin
		div_nxt = tick ? 16'h0000 : div_r + 16'h0001;
		count_nxt = count_r;
		if (init) begin
			count_nxt = {W{1'b0}};
		end else if (load) begin
			count_nxt = load_val;
		end else if (tick && run) begin
			count_nxt = count_r + {{(W-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			div_r <= 16'h0000;
			count_r <= {W{1'b0}};
		end else begin
			div_r <= div_nxt;
			count_r <= count_nxt;
		end
	end

endmodule // wdcs_cnt

// *** verilog/wdcs_gbit.v ***
// One write-gated control bit with hardware set and synchronous re-initialisation
`timescale 1ns/100ps
module wdcs_gbit #(
	parameter RST_VAL = 1'b0
) (
	input wire clk,
	input wire rst_n,
	input wire init,
	input wire hw_set,
	input wire wr,
	input wire allow,
	input wire gate_in,
	input wire data_in,
	output reg q_r
);

	reg q_nxt;

	always @* begin
		q_nxt = q_r;
		// Hardware set beats a software clear in the same cycle
		if (hw_set) begin
			q_nxt = 1'b1;
		end else if (init) begin
			q_nxt = RST_VAL;
		end else if (wr && allow && !gate_in) begin
			q_nxt = data_in;
		end
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			q_r <= RST_VAL;
		end else begin
			q_r <= q_nxt;
		end
	end

endmodule // wdcs_gbit

// *** verilog/wdcs_map.vh ***
// Register map, field positions, reset values and counts of the watchdog control block
`ifndef WDCS_MAP_VH
`define WDCS_MAP_VH

// Byte offsets on the register bus
`define WDCS_OFS_CTRL 5'h00
`define WDCS_OFS_COUNT 5'h04
`define WDCS_OFS_IRQ_STAT 5'h08
`define WDCS_OFS_IRQ_EN 5'h0C
`define WDCS_OFS_IRQ_CLR 5'h10

// Control/status register fields
`define WDCS_BIT_CWE_GATE 7
`define WDCS_BIT_CWE 6
`define WDCS_BIT_CTRL_GATE 5
`define WDCS_BIT_CTRL_WE 4
`define WDCS_BIT_RUN_GATE 3
`define WDCS_BIT_RUN 2
`define WDCS_BIT_FLAG_GATE 1
`define WDCS_BIT_FLAG 0

// Reset values of the controlled bits
`define WDCS_RST_CWE 1'b0
`define WDCS_RST_CTRL_WE 1'b0
`define WDCS_RST_RUN 1'b1
`define WDCS_RST_FLAG 1'b0

// Interrupt status fields
`define WDCS_IRQ_OVF 0
`define WDCS_IRQ_PROT 1
`define WDCS_IRQ_W 2

// Counter defaults
`define WDCS_CNT_W 8
`define WDCS_TICK_DIV 1

`endif

// *** verilog/wdcs_top.v ***
// Watchdog control/status register with write protection, counter and Avalon-MM slave
`timescale 1ns/100ps
`include "wdcs_map.vh"

module wdcs_top #(
	parameter CNT_W = `WDCS_CNT_W,
	parameter TICK_DIV = `WDCS_TICK_DIV
) (
	input wire CLK_SYS,
	input wire RST_N,
	input wire [4:0] AVS_ADDRESS,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	input wire [3:0] AVS_BYTEENABLE,
	output reg [31:0] AVS_READDATA,
	output wire AVS_WAITREQUEST,
	output wire IRQ,
	output reg INT_RST_OUT,
	output wire WDT_RUN,
	output wire WDT_RESET_FLAG
);

	////////////////////////////////////////////////////////////////////////////////
	// Bus handshake

	reg ack_r;
	wire req;
	wire wr_fire;
	wire rd_fire;
	wire [2:0] word_sel;

	// One wait state: read data is built at the first edge and taken at the second
	assign req = AVS_READ | AVS_WRITE;
	assign AVS_WAITREQUEST = req & ~ack_r;
	assign wr_fire = AVS_WRITE & ack_r & AVS_BYTEENABLE[0];
	// A read's data is captured in its first cycle, while waitrequest is still high
	assign rd_fire = AVS_READ & ~ack_r;
	assign word_sel = AVS_ADDRESS[4:2];

	function is_word;
		input [2:0] sel;
		input [4:0] ofs;
		begin
			is_word = (sel == ofs[4:2]);
		end
	endfunction

	wire sel_ctrl;
	wire sel_count;
	wire sel_stat;
	wire sel_en;
	wire sel_clr;

	// Decoded once so that the write strobes and the read mux always agree on the map
	assign sel_ctrl = is_word(word_sel, `WDCS_OFS_CTRL);
	assign sel_count = is_word(word_sel, `WDCS_OFS_COUNT);
	assign sel_stat = is_word(word_sel, `WDCS_OFS_IRQ_STAT);
	assign sel_en = is_word(word_sel, `WDCS_OFS_IRQ_EN);
	assign sel_clr = is_word(word_sel, `WDCS_OFS_IRQ_CLR);

	always @(posedge CLK_SYS) begin
		if (!RST_N) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req & ~ack_r;
		end
	end

	wire wr_ctrl;
	wire wr_count;
	wire wr_irq_en;
	wire wr_irq_clr;

	assign wr_ctrl = wr_fire & sel_ctrl;
	assign wr_count = wr_fire & sel_count;
	assign wr_irq_en = wr_fire & sel_en;
	assign wr_irq_clr = wr_fire & sel_clr;

	////////////////////////////////////////////////////////////////////////////////
	// Control bits

	wire cwe;
	wire ctrl_we;
	wire run;
	wire flag;
	wire ovf;
	wire [7:0] wd;

	assign wd = AVS_WRITEDATA[7:0];

	// Gate and data halves of a control write
	wire cwe_gate;
	wire cwe_data;
	wire ctrl_gate;
	wire ctrl_data;
	wire run_gate;
	wire run_data;
	wire flag_gate;
	wire flag_data;

	assign cwe_gate = wd[`WDCS_BIT_CWE_GATE];
	assign cwe_data = wd[`WDCS_BIT_CWE];
	assign ctrl_gate = wd[`WDCS_BIT_CTRL_GATE];
	assign ctrl_data = wd[`WDCS_BIT_CTRL_WE];
	assign run_gate = wd[`WDCS_BIT_RUN_GATE];
	assign run_data = wd[`WDCS_BIT_RUN];
	assign flag_gate = wd[`WDCS_BIT_FLAG_GATE];
	assign flag_data = wd[`WDCS_BIT_FLAG];

	// Bit 6: gated by bit 7 only
	wdcs_gbit #(
		.RST_VAL(`WDCS_RST_CWE)
	) u_cwe (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.init(ovf),
		.hw_set(1'b0),
		.wr(wr_ctrl),
		.allow(1'b1),
		.gate_in(cwe_gate),
		.data_in(cwe_data),
		.q_r(cwe)
	);

	// Bit 4: gated by bit 5 only
	wdcs_gbit #(
		.RST_VAL(`WDCS_RST_CTRL_WE)
	) u_ctrl_we (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.init(ovf),
		.hw_set(1'b0),
		.wr(wr_ctrl),
		.allow(1'b1),
		.gate_in(ctrl_gate),
		.data_in(ctrl_data),
		.q_r(ctrl_we)
	);

	// Run bit: gate bit 3, needs bit 4, back to 1 on any reset
	wdcs_gbit #(
		.RST_VAL(`WDCS_RST_RUN)
	) u_run (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.init(ovf),
		.hw_set(1'b0),
		.wr(wr_ctrl),
		.allow(ctrl_we),
		.gate_in(run_gate),
		.data_in(run_data),
		.q_r(run)
	);

	// Reset flag: set by overflow, cleared only by the pin or a gated write
	// A 1 written to the flag is ignored: software may only clear it, never fake an overflow
	wdcs_gbit #(
		.RST_VAL(`WDCS_RST_FLAG)
	) u_flag (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.init(1'b0),
		.hw_set(ovf),
		.wr(wr_ctrl & ~flag_data),
		.allow(ctrl_we),
		.gate_in(flag_gate),
		.data_in(1'b0),
		.q_r(flag)
	);

	assign WDT_RUN = run;
	assign WDT_RESET_FLAG = flag;

	////////////////////////////////////////////////////////////////////////////////
	// Counter

	wire [CNT_W-1:0] count;
	wire [CNT_W-1:0] cnt_wdata;
	wire cnt_load;

	// Only the low CNT_W bits of a write reach the counter
	assign cnt_wdata = AVS_WRITEDATA[CNT_W-1:0];
	assign cnt_load = wr_count & cwe;

	// Counts only while run is 1
	wdcs_cnt #(
		.W(CNT_W),
		.DIV(TICK_DIV)
	) u_cnt (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.init(ovf),
		.run(run),
		.load(cnt_load),
		.load_val(cnt_wdata),
		.count_r(count),
		.ovf(ovf)
	);

	// Overflow pulses the device-wide reset for one cycle
	always @(posedge CLK_SYS) begin
		if (!RST_N) begin
			INT_RST_OUT <= 1'b0;
		end else begin
			INT_RST_OUT <= ovf;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupts

	reg [`WDCS_IRQ_W-1:0] irq_stat_r;
	reg [`WDCS_IRQ_W-1:0] irq_stat_nxt;
	reg [`WDCS_IRQ_W-1:0] irq_en_r;
	wire [`WDCS_IRQ_W-1:0] irq_ev;
	wire [`WDCS_IRQ_W-1:0] irq_wdata;
	wire prot_cnt;
	wire prot_ctrl;
	wire prot_hit;

	assign irq_wdata = AVS_WRITEDATA[`WDCS_IRQ_W-1:0];

	// A rejected write to a protected bit or to the counter is worth telling software about
	assign prot_cnt = wr_count & ~cwe;
	// Bits 6 and 4 are never refused, so only the run and flag gates count here
	assign prot_ctrl = wr_ctrl & ~ctrl_we & (~run_gate | ~flag_gate);
	assign prot_hit = prot_cnt | prot_ctrl;

	assign irq_ev[`WDCS_IRQ_OVF] = ovf;
	assign irq_ev[`WDCS_IRQ_PROT] = prot_hit;

	always @* begin
		irq_stat_nxt = irq_stat_r;
		if (wr_irq_clr) begin
			irq_stat_nxt = irq_stat_nxt & ~irq_wdata;
		end
		// Set after clear so a same-cycle event is kept
		irq_stat_nxt = irq_stat_nxt | irq_ev;
	end

	always @(posedge CLK_SYS) begin
		if (!RST_N) begin
			irq_stat_r <= {`WDCS_IRQ_W{1'b0}};
			irq_en_r <= {`WDCS_IRQ_W{1'b0}};
		end else begin
			irq_stat_r <= irq_stat_nxt;
			if (wr_irq_en) begin
				irq_en_r <= irq_wdata;
			end
		end
	end

	assign IRQ = |(irq_stat_r & irq_en_r);

	////////////////////////////////////////////////////////////////////////////////
	// Read path

	reg [31:0] rd_nxt;
	wire [7:0] ctrl_view;

	// Gate bits are never stored and always read back as 1
	assign ctrl_view = {1'b1, cwe, 1'b1, ctrl_we, 1'b1, run, 1'b1, flag};

	always @* begin
		rd_nxt = 32'h0000_0000;
		if (sel_ctrl) begin
			rd_nxt[7:0] = ctrl_view;
		end else if (sel_count) begin
			rd_nxt[CNT_W-1:0] = count;
		end else if (sel_stat) begin
			rd_nxt[`WDCS_IRQ_W-1:0] = irq_stat_r;
		end else if (sel_en) begin
			rd_nxt[`WDCS_IRQ_W-1:0] = irq_en_r;
		end else if (sel_clr) begin
			// The clear register is write-only and reads as zero
			rd_nxt = 32'h0000_0000;
		end
	end

	// Captured at the first edge of a read; the value is that of the request cycle
	always @(posedge CLK_SYS) begin
		if (!RST_N) begin
			AVS_READDATA <= 32'h0000_0000;
		end else if (rd_fire) begin
			AVS_READDATA <= rd_nxt;
		end
	end

endmodule // wdcs_top
